// file: design/ccr_pkg.sv
/*
 condition code register block: shared constants, field positions, operation codes and carrier structs.
 assumes a 16-bit execution datapath, a 36-bit multiply accumulator and a 32-bit apb register bus.
*/
package ccr_pkg;
   // register byte offsets on the apb slave
   localparam logic [7:0] CCR_OFF_CCR = 8'h00;
   localparam logic [7:0] CCR_OFF_STAT = 8'h04;
   localparam logic [7:0] CCR_OFF_MASK = 8'h08;
   localparam logic [7:0] CCR_OFF_AM = 8'h0c;
   // condition code register field positions
   localparam int CCR_B_STOPSEL = 15;
   localparam int CCR_B_MV = 14;
   localparam int CCR_B_H = 13;
   localparam int CCR_B_EV = 12;
   localparam int CCR_B_N = 11;
   localparam int CCR_B_Z = 10;
   localparam int CCR_B_V = 9;
   localparam int CCR_B_C = 8;
   localparam int CCR_B_IP = 5;
   localparam int CCR_B_SM = 4;
   localparam int CCR_B_PK = 0;
   // status / mask bit positions
   localparam int CCR_S_MV = 0;
   localparam int CCR_S_EV = 1;
   localparam int CCR_S_STOP = 2;
   localparam int CCR_S_IRQ = 3;
   localparam int CCR_NSTAT = 4;
   // reset values
   localparam logic [15:0] CCR_RST_CCR = 16'h0000;
   localparam logic [3:0] CCR_RST_MASK = 4'h0;
   localparam logic [35:0] CCR_RST_AM = 36'h0_0000_0000;
   // saturation limits and rounding constant for accumulator reads
   localparam logic [31:0] CCR_SAT_POS = 32'h7fff_ffff;
   localparam logic [31:0] CCR_SAT_NEG = 32'h8000_0000;
   localparam logic [31:0] CCR_RND_ADD = 32'h0000_8000;
   localparam logic [31:0] CCR_RND_MSK = 32'hffff_0000;

   typedef enum logic [2:0] {
      FU_ADD = 3'b000,
      FU_SUB = 3'b001,
      FU_AND = 3'b010,
      FU_OR = 3'b011,
      FU_READ = 3'b100,
      FU_SHL = 3'b101,
      FU_SHR = 3'b110
   } ccr_fu_op_t;

   typedef enum logic [1:0] {
      CO_WRITE = 2'b00,
      CO_AND = 2'b01,
      CO_OR = 2'b10
   } ccr_op_kind_t;

   // one datapath operation whose flags land in the register
   typedef struct packed {
      logic valid;
      ccr_fu_op_t op;
      logic byte_mode;
      logic [15:0] a;
      logic [15:0] b;
   } ccr_fu_req_t;

   // dedicated register-modifying instruction
   typedef struct packed {
      logic valid;
      ccr_op_kind_t kind;
      logic [15:0] data;
   } ccr_op_t;

   // multiply-accumulate step
   typedef struct packed {
      logic valid;
      logic clear;
      logic [35:0] addend;
   } ccr_mac_req_t;
endpackage : ccr_pkg

// file: design/ccr_flag_unit.sv
/*
 combinational flag unit: computes result, negative, zero, overflow, carry and half carry of one operation.
 assumes the caller samples the outputs in the same cycle as the request.
*/
`timescale 1ns/1ps
`default_nettype none
module ccr_flag_unit (
   // request
   input wire ccr_pkg::ccr_fu_req_t req,
   input wire logic carry_in,
   // result and flags
   output logic [15:0] result,
   output logic n,
   output logic z,
   output logic v,
   output logic c,
   output logic h
);
   import ccr_pkg::*;

   // sign bit of an operand at the selected width
   function automatic logic msb_of(input logic [15:0] x, input logic bm);
      msb_of = bm ? x[7] : x[15];
   endfunction : msb_of

   logic [15:0] a16;
   logic [15:0] b16;
   logic [16:0] r17;
   logic [4:0] nib;

   assign a16 = req.byte_mode ? {8'h00, req.a[7:0]} : req.a;
   assign b16 = req.byte_mode ? {8'h00, req.b[7:0]} : req.b;
   assign nib = {1'b0, a16[3:0]} + {1'b0, b16[3:0]};

   // operation and carry; zero extension puts the carry or borrow in bit 8 or 16
   always_comb begin
      r17 = 17'h0_0000;
      c = carry_in;
      h = 1'b0;
      v = 1'b0;
      case (req.op)
         FU_ADD: begin
            r17 = {1'b0, a16} + {1'b0, b16};
            c = req.byte_mode ? r17[8] : r17[16];
            h = nib[4];
            v = (msb_of(a16, req.byte_mode) == msb_of(b16, req.byte_mode)) &&
                (msb_of(r17[15:0], req.byte_mode) != msb_of(a16, req.byte_mode));
         end
         FU_SUB: begin
            r17 = {1'b0, a16} - {1'b0, b16};
            c = req.byte_mode ? r17[8] : r17[16];
            v = (msb_of(a16, req.byte_mode) != msb_of(b16, req.byte_mode)) &&
                (msb_of(r17[15:0], req.byte_mode) != msb_of(a16, req.byte_mode));
         end
         FU_AND: r17 = {1'b0, a16 & b16};
         FU_OR: r17 = {1'b0, a16 | b16};
         FU_READ: r17 = {1'b0, a16};
         FU_SHL: begin
            r17 = {1'b0, a16[14:0], carry_in};
            c = msb_of(a16, req.byte_mode);
         end
         FU_SHR: begin
            r17 = req.byte_mode ? {9'h000, carry_in, a16[7:1]} : {1'b0, carry_in, a16[15:1]};
            c = a16[0];
         end
         default: r17 = 17'h0_0000;
      endcase
   end

   assign result = req.byte_mode ? {8'h00, r17[7:0]} : r17[15:0];
   assign n = msb_of(result, req.byte_mode);
   assign z = req.byte_mode ? (result[7:0] == 8'h00) : (result == 16'h0000);
endmodule : ccr_flag_unit
`default_nettype wire

// file: design/ccr_core.sv
/*
 condition code register core: flags, stop select, saturation, interrupt mask level, pc page, accumulator.
 assumes an apb master on pclk and an execution unit that presents one request per cycle.
*/
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ccr_core (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // execution datapath
   input wire ccr_pkg::ccr_fu_req_t fu_req,
   input wire ccr_pkg::ccr_op_t ccr_op,
   input wire ccr_pkg::ccr_mac_req_t mac_req,
   input wire logic am_rd,
   input wire logic am_rd_round,
   input wire logic low_power_stop_instruction_exec,
   input wire logic [2:0] irq_level,
   input wire logic [15:0] pc,
   // results
   output logic [15:0] ccr_value,
   output logic [15:0] fu_result,
   output logic [31:0] am_rd_data,
   output logic [19:0] fetch_addr,
   output logic clk_stop,
   output logic stop_nop,
   output logic irq_accept,
   output logic irq
);
   import ccr_pkg::*;

   logic [15:0] ccr_q;
   logic [15:0] ccr_d;
   logic [35:0] am_q;
   logic sign_pre_q;
   logic [CCR_NSTAT-1:0] stat_q;
   logic [CCR_NSTAT-1:0] mask_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic [15:0] fu_result_q;
   logic [31:0] am_rd_data_q;
   logic [19:0] fetch_addr_q;
   logic clk_stop_q;
   logic stop_nop_q;
   logic irq_accept_q;
   logic irq_q;
   logic [15:0] fu_res;
   logic fu_n, fu_z, fu_v, fu_c, fu_h;
   logic [36:0] mac_sum;
   logic mac_mv, mac_ev;
   logic irq_ok;
   logic setup, wr_done, rd_done, addr_ok;
   logic [31:0] am_view;
   logic [CCR_NSTAT-1:0] stat_set;

   ccr_flag_unit u_flag (
      .req(fu_req),
      .carry_in(ccr_q[CCR_B_C]),
      .result(fu_res),
      .n(fu_n),
      .z(fu_z),
      .v(fu_v),
      .c(fu_c),
      .h(fu_h)
   );

   // apb phase decode; every transfer answers on its second cycle
   assign setup = psel & ~penable;
   assign wr_done = psel & penable & pready_q & pwrite;
   assign rd_done = psel & penable & pready_q & ~pwrite;
   assign addr_ok = (paddr == CCR_OFF_CCR) || (paddr == CCR_OFF_STAT) ||
                    (paddr == CCR_OFF_MASK) || (paddr == CCR_OFF_AM);

   // accumulate step: sum one bit wider to see the 36-bit signed overflow
   assign mac_sum = {am_q[35], am_q} + {mac_req.addend[35], mac_req.addend};
   assign mac_mv = mac_req.valid & ~mac_req.clear & (mac_sum[36] != mac_sum[35]);
   assign mac_ev = mac_req.valid & ~mac_req.clear &
                   ~((&mac_sum[35:31]) | ~(|mac_sum[35:31]));

   // request passes only at or above the mask level; level 0 means no request
   assign irq_ok = (irq_level != 3'b000) && (irq_level >= ccr_q[CCR_B_IP +: 3]);

   // saturated, rounded or plain view of the accumulator for transfer reads and bus reads
   always_comb begin
      if (ccr_q[CCR_B_SM] && (ccr_q[CCR_B_MV] || ccr_q[CCR_B_EV])) begin
         am_view = sign_pre_q ? CCR_SAT_NEG : CCR_SAT_POS;
      end else if (am_rd_round) begin
         am_view = (am_q[31:0] + CCR_RND_ADD) & CCR_RND_MSK;
      end else begin
         am_view = am_q[31:0];
      end
   end

   // next register value: bus write, then instruction, then datapath flags win
   always_comb begin
      ccr_d = ccr_q;
      if (wr_done && paddr == CCR_OFF_CCR) begin
         ccr_d = pwdata[15:0];
      end
      if (ccr_op.valid) begin
         case (ccr_op.kind)
            CO_WRITE: ccr_d = ccr_op.data;
            CO_AND: ccr_d = ccr_d & ccr_op.data;
            CO_OR: ccr_d = ccr_d | ccr_op.data;
            default: ccr_d = ccr_d;
         endcase
      end
      if (fu_req.valid) begin
         ccr_d[CCR_B_N] = fu_n;
         ccr_d[CCR_B_Z] = fu_z;
         ccr_d[CCR_B_V] = fu_v;
         if (fu_req.op == FU_ADD || fu_req.op == FU_SUB || fu_req.op == FU_SHL || fu_req.op == FU_SHR) begin
            ccr_d[CCR_B_C] = fu_c;
         end
         if (fu_req.op == FU_ADD) begin
            ccr_d[CCR_B_H] = fu_h;
         end
      end
      // overflow events are sticky until software or an instruction clears them
      if (mac_mv) begin
         ccr_d[CCR_B_MV] = 1'b1;
      end
      if (mac_ev) begin
         ccr_d[CCR_B_EV] = 1'b1;
      end
   end

   // condition code register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ccr_q <= CCR_RST_CCR;
      end else begin
         ccr_q <= ccr_d;
      end
   end

   // accumulator and the sign it had before the first overflow
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         am_q <= CCR_RST_AM;
         sign_pre_q <= 1'b0;
      end else if (mac_req.valid) begin
         am_q <= mac_req.clear ? CCR_RST_AM : mac_sum[35:0];
         if (!(ccr_q[CCR_B_MV] || ccr_q[CCR_B_EV]) && (mac_mv || mac_ev)) begin
            sign_pre_q <= am_q[35];
         end
      end
   end

   // datapath result, accumulator read and fetch address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fu_result_q <= 16'h0000;
         am_rd_data_q <= 32'h0000_0000;
         fetch_addr_q <= 20'h0_0000;
      end else begin
         if (fu_req.valid) begin
            fu_result_q <= fu_res;
         end
         if (am_rd) begin
            am_rd_data_q <= am_view;
         end
         fetch_addr_q <= {ccr_q[CCR_B_PK +: 4], pc};
      end
   end

   // low-power stop and interrupt acceptance; an accepted request wakes the clocks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_stop_q <= 1'b0;
         stop_nop_q <= 1'b0;
         irq_accept_q <= 1'b0;
      end else begin
         stop_nop_q <= low_power_stop_instruction_exec & ccr_q[CCR_B_STOPSEL];
         irq_accept_q <= irq_ok;
         if (low_power_stop_instruction_exec && !ccr_q[CCR_B_STOPSEL]) begin
            clk_stop_q <= 1'b1;
         end else if (irq_ok) begin
            clk_stop_q <= 1'b0;
         end
      end
   end

   // sticky status, cleared by a read; only the bits in the setup snapshot clear,
   // so an event after the snapshot or in the clearing cycle is not lost
   assign stat_set = {irq_ok, low_power_stop_instruction_exec & ~ccr_q[CCR_B_STOPSEL], mac_ev, mac_mv};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_q <= '0;
      end else if (rd_done && paddr == CCR_OFF_STAT) begin
         stat_q <= (stat_q & ~prdata_q[CCR_NSTAT-1:0]) | stat_set;
      end else begin
         stat_q <= stat_q | stat_set;
      end
   end

   // interrupt mask and level output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= CCR_RST_MASK;
         irq_q <= 1'b0;
      end else begin
         if (wr_done && paddr == CCR_OFF_MASK) begin
            mask_q <= pwdata[CCR_NSTAT-1:0];
         end
         irq_q <= |(stat_q & mask_q);
      end
   end

   // apb answer: data captured in the setup cycle, ready in the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= setup;
         pslverr_q <= setup & ~addr_ok;
         if (setup && !pwrite) begin
            case (paddr)
               CCR_OFF_CCR: prdata_q <= {16'h0000, ccr_q};
               CCR_OFF_STAT: prdata_q <= {28'h000_0000, stat_q};
               CCR_OFF_MASK: prdata_q <= {28'h000_0000, mask_q};
               CCR_OFF_AM: prdata_q <= am_view;
               default: prdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign ccr_value = ccr_q;
   assign fu_result = fu_result_q;
   assign am_rd_data = am_rd_data_q;
   assign fetch_addr = fetch_addr_q;
   assign clk_stop = clk_stop_q;
   assign stop_nop = stop_nop_q;
   assign irq_accept = irq_accept_q;
   assign irq = irq_q;

   // checks
   property p_stop_halt;
      @(posedge pclk) disable iff (!presetn)
      low_power_stop_instruction_exec && !ccr_q[CCR_B_STOPSEL] |=> clk_stop_q && !stop_nop_q;
   endproperty
   a_stop_halt: assert property (p_stop_halt) else $error("stop did not halt clocks");

   property p_stop_nop;
      @(posedge pclk) disable iff (!presetn)
      low_power_stop_instruction_exec && ccr_q[CCR_B_STOPSEL] && !clk_stop_q && !irq_ok |=> stop_nop_q && !clk_stop_q;
   endproperty
   a_stop_nop: assert property (p_stop_nop) else $error("stop select 1 did not give nop");

   property p_mv_set;
      @(posedge pclk) disable iff (!presetn)
      mac_req.valid && !mac_req.clear && (mac_sum[36] != mac_sum[35]) |=> ccr_q[CCR_B_MV];
   endproperty
   a_mv_set: assert property (p_mv_set) else $error("mac overflow flag not set");

   property p_h_set;
      @(posedge pclk) disable iff (!presetn)
      fu_req.valid && fu_req.op == FU_ADD && (fu_req.a[3:0] + fu_req.b[3:0] > 5'd15) |=> ccr_q[CCR_B_H];
   endproperty
   a_h_set: assert property (p_h_set) else $error("half carry not set");

   property p_ev_set;
      @(posedge pclk) disable iff (!presetn)
      mac_req.valid && !mac_req.clear && (mac_sum[35:31] != 5'h00) && (mac_sum[35:31] != 5'h1f)
      |=> ccr_q[CCR_B_EV];
   endproperty
   a_ev_set: assert property (p_ev_set) else $error("extension overflow flag not set");

   property p_nz;
      @(posedge pclk) disable iff (!presetn)
      fu_req.valid && fu_req.op == FU_READ && !fu_req.byte_mode
      |=> ccr_q[CCR_B_N] == $past(fu_req.a[15]) && ccr_q[CCR_B_Z] == ($past(fu_req.a) == 16'h0000);
   endproperty
   a_nz: assert property (p_nz) else $error("negative or zero flag wrong on read");

   property p_v_add;
      @(posedge pclk) disable iff (!presetn)
      fu_req.valid && fu_req.op == FU_ADD && !fu_req.byte_mode && fu_req.a == 16'h7fff && fu_req.b == 16'h0001
      |=> ccr_q[CCR_B_V] && ccr_q[CCR_B_N] && !ccr_q[CCR_B_C];
   endproperty
   a_v_add: assert property (p_v_add) else $error("signed overflow flag wrong");

   property p_c_sub;
      @(posedge pclk) disable iff (!presetn)
      fu_req.valid && fu_req.op == FU_SUB && !fu_req.byte_mode && fu_req.a < fu_req.b |=> ccr_q[CCR_B_C];
   endproperty
   a_c_sub: assert property (p_c_sub) else $error("borrow not in carry");

   property p_irq_mask;
      @(posedge pclk) disable iff (!presetn)
      irq_level < ccr_q[CCR_B_IP +: 3] |=> !irq_accept_q;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("low priority request accepted");

   property p_sat;
      @(posedge pclk) disable iff (!presetn)
      am_rd && ccr_q[CCR_B_SM] && (ccr_q[CCR_B_MV] || ccr_q[CCR_B_EV])
      |=> am_rd_data_q == CCR_SAT_POS || am_rd_data_q == CCR_SAT_NEG;
   endproperty
   a_sat: assert property (p_sat) else $error("saturated read not clamped");

   property p_page;
      @(posedge pclk) disable iff (!presetn)
      1'b1 |=> fetch_addr_q == {$past(ccr_q[3:0]), $past(pc)};
   endproperty
   a_page: assert property (p_page) else $error("fetch address page wrong");

   property p_hold;
      @(posedge pclk) disable iff (!presetn)
      !fu_req.valid && !ccr_op.valid && !mac_req.valid && !wr_done |=> $stable(ccr_q);
   endproperty
   a_hold: assert property (p_hold) else $error("register changed with no update");

   c_stop: cover property (@(posedge pclk) disable iff (!presetn) clk_stop_q ##1 !clk_stop_q);
   c_sat: cover property (@(posedge pclk) disable iff (!presetn) am_rd && ccr_q[CCR_B_SM] && ccr_q[CCR_B_EV]);
   c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq_q);
endmodule : ccr_core
`default_nettype wire

// file: bench/ccr_exec_model.sv
/*
 execution-side model: issues datapath ops, register instructions, accumulate steps, reads and stop/irq levels.
 assumes the bench calls its tasks; each request except the lvl levels is a one-cycle pulse launched right after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module ccr_exec_model
   import ccr_pkg::*;
(
   // clock
   input wire logic pclk,
   // requests toward the register block
   output var ccr_pkg::ccr_fu_req_t fu_req,
   output var ccr_pkg::ccr_op_t ccr_op,
   output var ccr_pkg::ccr_mac_req_t mac_req,
   output var logic am_rd,
   output var logic am_rd_round,
   output var logic low_power_stop_instruction_exec,
   output var logic [2:0] irq_level,
   output var logic [15:0] pc
);
   // idle at time zero
   initial begin
      fu_req = '0;
      ccr_op = '0;
      mac_req = '0;
      am_rd = 1'b0;
      am_rd_round = 1'b0;
      low_power_stop_instruction_exec = 1'b0;
      irq_level = 3'h0;
      pc = 16'h0000;
   end

   // released operands show inverted data so stale values never pass for a match
   task automatic fu(input ccr_fu_op_t op, input logic [15:0] a, input logic [15:0] b, input logic bm);
      @(posedge pclk);
      fu_req <= '{1'b1, op, bm, a, b};
      @(posedge pclk);
      fu_req <= '{1'b0, op, bm, ~a, ~b};
   endtask : fu

   // dedicated register instruction
   task automatic op(input ccr_op_kind_t k, input logic [15:0] d);
      @(posedge pclk);
      ccr_op <= '{1'b1, k, d};
      @(posedge pclk);
      ccr_op <= '{1'b0, k, ~d};
   endtask : op

   // one accumulate step
   task automatic mac(input logic clr, input logic [35:0] d);
      @(posedge pclk);
      mac_req <= '{1'b1, clr, d};
      @(posedge pclk);
      mac_req <= '{1'b0, 1'b0, ~d};
   endtask : mac

   // accumulator read, rounded or truncated
   task automatic amrd(input logic rnd);
      @(posedge pclk);
      am_rd <= 1'b1;
      am_rd_round <= rnd;
      @(posedge pclk);
      am_rd <= 1'b0;
   endtask : amrd

   // low-power stop instruction
   task automatic stop();
      @(posedge pclk);
      low_power_stop_instruction_exec <= 1'b1;
      @(posedge pclk);
      low_power_stop_instruction_exec <= 1'b0;
   endtask : stop

   // pending request priority and program counter are levels
   task automatic lvl(input logic [2:0] l, input logic [15:0] p);
      @(posedge pclk);
      irq_level <= l;
      pc <= p;
   endtask : lvl
endmodule : ccr_exec_model
`default_nettype wire

// file: bench/condition_code_status_register_tb.sv
/*
 self-checking bench for the condition code register block: apb accesses and datapath sequences.
 assumes ccr_core on a 10 MHz pclk and the execution model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module condition_code_status_register_tb;
   import ccr_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, am_rd, am_rd_round, low_power_stop_instruction_exec;
   logic clk_stop, stop_nop, irq_accept, irq, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, am_rd_data, rd;
   logic [2:0] irq_level;
   logic [15:0] pc, ccr_value, fu_result;
   logic [19:0] fetch_addr;
   ccr_fu_req_t fu_req;
   ccr_op_t ccr_op;
   ccr_mac_req_t mac_req;
   int miscompares = 0;
   int cmp_count = 0;

   ccr_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fu_req(fu_req), .ccr_op(ccr_op), .mac_req(mac_req), .am_rd(am_rd), .am_rd_round(am_rd_round),
      .low_power_stop_instruction_exec(low_power_stop_instruction_exec), .irq_level(irq_level), .pc(pc), .ccr_value(ccr_value),
      .fu_result(fu_result), .am_rd_data(am_rd_data), .fetch_addr(fetch_addr), .clk_stop(clk_stop),
      .stop_nop(stop_nop), .irq_accept(irq_accept), .irq(irq));
   ccr_exec_model exec (.pclk(pclk), .fu_req(fu_req), .ccr_op(ccr_op), .mac_req(mac_req), .am_rd(am_rd),
      .am_rd_round(am_rd_round), .low_power_stop_instruction_exec(low_power_stop_instruction_exec), .irq_level(irq_level), .pc(pc));

   // 100 ns clock
   always #50 pclk = ~pclk;

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : summarize

   task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // apb master: request held until pready is sampled high, bounded wait
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         chk("pready", 1, pready);
         summarize();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // one datapath op, then result and {h,n,z,v,c}
   task automatic fchk(input ccr_fu_op_t op, input logic [15:0] a, b, r, input logic [4:0] f);
      exec.fu(op, a, b, 1'b0);
      #1;
      chk("fu_result", r, fu_result);
      chk("flags", f, {ccr_value[13], ccr_value[11:8]});
   endtask : fchk

   task automatic settle();
      repeat (2) @(posedge pclk);
      #1;
   endtask : settle

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, CCR_OFF_CCR, 0);
      chk("ccr reset", CCR_RST_CCR, rd);
      apb(0, CCR_OFF_MASK, 0);
      chk("mask reset", CCR_RST_MASK, rd);
      // flag updates, carry kept by logic ops, rotates through carry
      fchk(FU_ADD, 16'h7fff, 16'h0001, 16'h8000, 5'b11010);
      fchk(FU_ADD, 16'hffff, 16'h0001, 16'h0000, 5'b10101);
      fchk(FU_SUB, 16'h0000, 16'h0001, 16'hffff, 5'b11001);
      fchk(FU_AND, 16'hf0f0, 16'h0f0f, 16'h0000, 5'b10101);
      fchk(FU_OR, 16'h8000, 16'h0001, 16'h8001, 5'b11001);
      fchk(FU_READ, 16'h0000, 16'h0000, 16'h0000, 5'b10101);
      fchk(FU_ADD, 16'h0001, 16'h0001, 16'h0002, 5'b00000);
      fchk(FU_SHL, 16'h8000, 16'h0000, 16'h0000, 5'b00101);
      fchk(FU_SHR, 16'h0001, 16'h0000, 16'h8000, 5'b01001);
      fchk(FU_SUB, 16'h8000, 16'h0001, 16'h7fff, 5'b00010);
      fchk(FU_ADD, 16'h0008, 16'h0008, 16'h0010, 5'b10000);
      // byte mode: upper byte ignored, carry and sign from bit 7
      exec.fu(FU_ADD, 16'hff88, 16'h0088, 1'b1);
      #1 chk("byte result", 16'h0010, fu_result);
      chk("byte flags", 5'b10011, {ccr_value[13], ccr_value[11:8]});
      // dedicated instructions
      exec.op(CO_WRITE, 16'h00ff);
      #1 chk("ccr", 16'h00ff, ccr_value);
      exec.op(CO_AND, 16'h0f0f);
      #1 chk("ccr", 16'h000f, ccr_value);
      exec.op(CO_OR, 16'h8100);
      #1 chk("ccr", 16'h810f, ccr_value);
      apb(0, CCR_OFF_CCR, 0);
      chk("ccr read", 32'h0000_810f, rd);
      // page 0xa, priority 3
      apb(1, CCR_OFF_CCR, 32'h0000_006a);
      exec.lvl(3'd2, 16'h1234);
      settle();
      chk("fetch_addr", 20'ha1234, fetch_addr);
      apb(1, 8'h10, 32'hffff_ffff);
      chk("pslverr", 1, er);
      apb(0, 8'h10, 0);
      chk("unmapped", 33'h1_0000_0000, {er, rd});
      apb(0, CCR_OFF_CCR, 0);
      chk("ccr kept", 32'h0000_006a, rd);
      apb(1, CCR_OFF_MASK, 32'h0000_0008);
      settle();
      chk("irq low prio", 2'b00, {irq_accept, irq});
      exec.lvl(3'd3, 16'h1234);
      settle();
      chk("irq equal prio", 2'b11, {irq_accept, irq});
      exec.lvl(3'd0, 16'h1234);
      apb(0, CCR_OFF_STAT, 0);
      chk("status", 32'h0000_0008, rd);
      apb(0, CCR_OFF_STAT, 0);
      chk("status cleared", 32'h0000_0000, rd);
      settle();
      chk("irq cleared", 0, irq);
      // stop select 0 halts until an accepted request, 1 is a no-operation
      apb(1, CCR_OFF_CCR, 0);
      exec.stop();
      #1 chk("clk_stop", 1, clk_stop);
      exec.lvl(3'd1, 16'h1234);
      settle();
      chk("clk_stop wake", 0, clk_stop);
      exec.lvl(3'd0, 16'h1234);
      apb(1, CCR_OFF_CCR, 32'h0000_8000);
      exec.stop();
      #1 chk("stop_nop", 2'b01, {clk_stop, stop_nop});
      apb(0, CCR_OFF_STAT, 0);
      chk("status", 32'h0000_000c, rd);
      // saturation, positive then negative
      apb(1, CCR_OFF_CCR, 32'h0000_0010);
      exec.mac(1, 0);
      exec.mac(0, 36'h0_7fff_ffff);
      exec.mac(0, 36'h0_0000_0001);
      #1 chk("mv h ev", 3'b001, ccr_value[14:12]);
      exec.amrd(0);
      #1 chk("am sat pos", 32'h7fff_ffff, am_rd_data);
      apb(1, CCR_OFF_CCR, 32'h0000_0010);
      exec.mac(1, 0);
      exec.mac(0, 36'hf_8000_0000);
      exec.mac(0, 36'hf_ffff_ffff);
      #1 chk("ev neg", 1, ccr_value[12]);
      exec.amrd(1);
      #1 chk("am sat neg", 32'h8000_0000, am_rd_data);
      apb(1, CCR_OFF_CCR, 0);
      exec.mac(1, 0);
      exec.mac(0, 36'h7_ffff_ffff);
      exec.mac(0, 36'h0_0000_0001);
      #1 chk("mv", 1, ccr_value[14]);
      exec.amrd(0);
      #1 chk("am no sat", 32'h0000_0000, am_rd_data);
      // no saturation: rounded and truncated transfer reads, and the bus view
      exec.mac(1, 0);
      exec.mac(0, 36'h0_0001_8000);
      exec.amrd(1);
      #1 chk("am rounded", 32'h0002_0000, am_rd_data);
      exec.amrd(0);
      #1 chk("am truncated", 32'h0001_8000, am_rd_data);
      apb(0, CCR_OFF_AM, 0);
      chk("am view", 32'h0001_8000, rd);
      summarize();
   end
endmodule : condition_code_status_register_tb
`default_nettype wire
